// *** bench/eds_phy_model.sv ***
// Stand-in for the PHY: carrier over a frame when carrier_ok is set, and a collision test pulse after it when sqe_ok is set
`timescale 1ns/1ps
`default_nettype none
module eds_phy_model (
    input wire logic ref_clk,
    input wire logic tx_start,
    input wire logic tx_end,
    input wire logic carrier_ok,
    input wire logic sqe_ok,
    input wire logic col_kick,
    output logic phy_crs,
    output logic phy_col
);
    logic crs_q = 1'b0;
    logic col_q = 1'b0;
    int cnt = 0;
    // Carrier spans the frame only when asked; test pulse lands a few cycles after the frame
    always_ff @(posedge ref_clk) begin
        crs_q <= tx_start ? carrier_ok : (tx_end ? 1'b0 : crs_q);
        cnt <= (tx_end && sqe_ok) ? 7 : ((cnt > 0) ? cnt - 1 : 0);
        col_q <= ((cnt >= 1) && (cnt <= 3)) | col_kick;
    end
    assign phy_crs = crs_q;
    assign phy_col = col_q;
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the descriptor status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, speed_10 = 1, immediate_halt = 0;
    logic rx_run_enable = 1, rx_long_enable = 0, rx_good_irq_enable = 1, tx_done_irq_enable = 0;
    logic tx_start = 0, tx_byte = 0, tx_end = 0, tx_fifo_empty = 0, tx_fifo_parity_fault = 0;
    logic tx_defer_active = 0, rx_start = 0, rx_byte = 0, rx_fifo_full = 0, rx_fifo_parity_fault = 0;
    logic rx_end = 0, rx_entry_valid = 0, wb_ready = 1, carrier_ok = 1, sqe_ok = 1, col_kick = 0;
    logic phy_col, phy_crs, rx_good_irq, tx_busy, wb_valid;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic [31:0] reg_rdata, got;
    eds_pkg::eds_rx_entry_s rx_entry = '0;
    eds_pkg::eds_wb_s wb_data;
    int miscompares = 0, checked = 0;
    typedef struct {logic [15:0] a; logic w; logic [31:0] d; logic [31:0] e;} eds_row_s;
    eds_row_s rows [11] = '{
        '{16'h9008, 1'b1, 32'h00001000, 32'h00001000},
        '{16'h900C, 1'b1, 32'h00002004, 32'h00002004},
        '{16'h9010, 1'b1, 32'h000005EE, 32'h000005EE},
        '{16'h9000, 1'b1, 32'h00004000, 32'h00004000},
        '{16'h9050, 1'b1, 32'h12345678, 32'h00000000},
        '{16'h9200, 1'b1, 32'hA5A5A5A5, 32'h00000000},
        '{16'h9018, 1'b1, 32'h00000001, 32'h00000001},
        '{16'h9204, 1'b1, 32'h5A5A5A5A, 32'h5A5A5A5A},
        '{16'h9800, 1'b0, 32'h00000000, 32'h00000001},
        '{16'h9804, 1'b0, 32'h00000000, 32'h00000000},
        '{16'h9904, 1'b0, 32'h00000000, 32'hCAFE0001}
    };
    eds_core #(.DEFER10_CYCLES(40)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phy_col(phy_col),
        .phy_crs(phy_crs), .speed_10(speed_10), .immediate_halt(immediate_halt), .rx_run_enable(rx_run_enable),
        .rx_long_enable(rx_long_enable), .rx_good_irq_enable(rx_good_irq_enable),
        .tx_done_irq_enable(tx_done_irq_enable), .tx_start(tx_start), .tx_byte(tx_byte), .tx_end(tx_end),
        .tx_fifo_empty(tx_fifo_empty), .tx_fifo_parity_fault(tx_fifo_parity_fault),
        .tx_defer_active(tx_defer_active), .rx_start(rx_start), .rx_byte(rx_byte), .rx_fifo_full(rx_fifo_full),
        .rx_fifo_parity_fault(rx_fifo_parity_fault), .rx_end(rx_end), .rx_entry(rx_entry),
        .rx_entry_valid(rx_entry_valid), .rx_good_irq(rx_good_irq), .tx_busy(tx_busy), .wb_valid(wb_valid),
        .wb_data(wb_data), .wb_ready(wb_ready));
    eds_phy_model i_phy (.ref_clk(ref_clk), .tx_start(tx_start), .tx_end(tx_end), .carrier_ok(carrier_ok),
        .sqe_ok(sqe_ok), .col_kick(col_kick), .phy_crs(phy_crs), .phy_col(phy_col));
    always #50 ref_clk = ~ref_clk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask
    // Wait for a status word, then compare the masked fields; wb_ready is left as the caller set it
    task automatic take(input logic t, input logic [31:0] m, input logic [31:0] e);
        int k;
        k = 0;
        #1;
        while (wb_valid !== 1'b1 && k < 80) begin
            @(posedge ref_clk);
            #1 k++;
        end
        if (wb_valid !== 1'b1) begin
            chk("wb_valid", 32'h1, {31'h0, wb_valid});
            wrap_up();
        end
        chk("wb_is_tx", {31'h0, t}, {31'h0, wb_data.is_tx});
        chk("wb_word", e, wb_data.word & m);
    endtask
    task automatic rxf(input int n, input logic ov, input logic par, input logic halt,
        input logic [31:0] m, input logic [31:0] e);
        logic g;
        @(posedge ref_clk);
        rx_start <= 1'b1;
        @(posedge ref_clk);
        rx_start <= 1'b0;
        rx_fifo_parity_fault <= par;
        repeat (n) begin
            @(posedge ref_clk);
            rx_byte <= 1'b1;
            rx_fifo_full <= ov;
            rx_fifo_parity_fault <= 1'b0;
        end
        @(posedge ref_clk);
        rx_byte <= 1'b0;
        rx_fifo_full <= 1'b0;
        rx_run_enable <= ~halt;
        rx_end <= ~halt;
        @(posedge ref_clk);
        rx_end <= 1'b0;
        take(1'b0, m, e);
        rx_run_enable <= 1'b1;
        g = 1'b0;
        repeat (3) begin
            @(posedge ref_clk);
            #1 g = g | rx_good_irq;
        end
        chk("rx_good_irq", {31'h0, e[30] & rx_good_irq_enable}, {31'h0, g});
    endtask
    task automatic txf(input int n, input int nc, input int c0, input logic crs, input logic sqe, input logic emp,
        input logic par, input int dfr, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk);
        carrier_ok <= crs;
        sqe_ok <= sqe;
        tx_start <= 1'b1;
        @(posedge ref_clk);
        tx_start <= 1'b0;
        if (dfr > 0) begin
            tx_defer_active <= 1'b1;
            repeat (dfr) @(posedge ref_clk);
            tx_defer_active <= 1'b0;
        end
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            tx_byte <= 1'b1;
            tx_fifo_empty <= emp;
            tx_fifo_parity_fault <= par && i == 5;
            col_kick <= (i >= c0) && (i < c0 + 2 * nc) && i[0];
        end
        @(posedge ref_clk);
        tx_byte <= 1'b0;
        tx_fifo_empty <= 1'b0;
        col_kick <= 1'b0;
        tx_end <= 1'b1;
        @(posedge ref_clk);
        tx_end <= 1'b0;
        #1 chk("tx_busy", 32'h1, {31'h0, tx_busy});
        take(1'b1, m, e);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rx_entry_valid <= 1'b1;
        rx_entry <= '{data: 32'h11111111, eof: 1'b1};
        @(posedge ref_clk);
        rx_entry <= '{data: 32'hCAFE0001, eof: 1'b0};
        @(posedge ref_clk);
        rx_entry_valid <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk("reg_rdata", rows[i].e, got);
        end
        $display("register map test done");
        rxf(64, 0, 0, 0, 32'hEC000000, 32'h40000000);
        rxf(20, 1, 0, 0, 32'hEC000000, 32'h04000000);
        rxf(20, 0, 1, 0, 32'hEC000000, 32'h20000000);
        rxf(1519, 0, 0, 0, 32'hEC000000, 32'h08000000);
        rxf(1518, 0, 0, 0, 32'hEC000000, 32'h40000000);
        rx_long_enable <= 1'b1;
        rxf(1519, 0, 0, 0, 32'hEC000000, 32'h40000000);
        rx_good_irq_enable <= 1'b0;
        rxf(30, 0, 0, 1, 32'hEC000000, 32'h80000000);
        rxf(30, 0, 0, 0, 32'hEC000000, 32'h40000000);
        $display("receive status test done");
        txf(70, 0, 0, 1, 1, 0, 0, 0, 32'hFF9F0000, 32'h40000000);
        tx_done_irq_enable <= 1'b1;
        txf(70, 0, 0, 1, 1, 0, 0, 0, 32'hFF9F0000, 32'h40800000);
        tx_done_irq_enable <= 1'b0;
        txf(70, 0, 0, 0, 1, 0, 0, 0, 32'hFF800000, 32'hC4800000);
        txf(70, 0, 0, 1, 0, 0, 0, 0, 32'h48000000, 32'h48000000);
        txf(70, 0, 0, 1, 1, 1, 0, 0, 32'h41000000, 32'h41000000);
        txf(70, 0, 0, 1, 1, 0, 0, 45, 32'h02000000, 32'h02000000);
        txf(70, 0, 0, 1, 1, 0, 1, 0, 32'hFF800000, 32'hE0800000);
        txf(70, 3, 0, 1, 1, 0, 0, 0, 32'hFF9F0000, 32'h40030000);
        txf(70, 1, 62, 1, 1, 0, 0, 0, 32'hFF9F0000, 32'hD0810000);
        speed_10 <= 1'b0;
        txf(70, 0, 0, 1, 1, 0, 0, 45, 32'h02000000, 32'h00000000);
        txf(70, 0, 0, 1, 1, 0, 0, 3300, 32'h02000000, 32'h02000000);
        @(posedge ref_clk);
        wb_ready <= 1'b0;
        txf(70, 16, 0, 1, 1, 0, 0, 0, 32'hFF9F0000, 32'hC0900000);
        wb_ready <= 1'b1;
        rd(16'h9014);
        chk("dma_status", 32'h3, got & 32'h3);
        wr(16'h9014, 32'h00000003);
        rd(16'h9014);
        chk("dma_status", 32'h0, got & 32'h3);
        $display("transmit status test done");
        resetn <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk("reset_outputs", 32'h0, {28'h0, tx_busy, wb_valid, rx_good_irq, |reg_rdata});
        resetn <= 1'b1;
        rd(16'h9008);
        chk("tx_ptr_reset", 32'hFFFFFFFF, got);
        rd(16'h900C);
        chk("rx_ptr_reset", 32'hFFFFFFFF, got);
        rd(16'h9000);
        chk("tx_ctl_reset", 32'h00000000, got);
        $display("reset test done");
        wrap_up();
    end
endmodule
`default_nettype wire

// *** rtl/eds_consts.svh ***
// Offsets, field positions, reset values and timing counts for the descriptor status block
`ifndef EDS_CONSTS_SVH
`define EDS_CONSTS_SVH
`define EDS_OFF_TX_CTRL 16'h9000
`define EDS_OFF_RX_CTRL 16'h9004
`define EDS_OFF_TX_PTR 16'h9008
`define EDS_OFF_RX_PTR 16'h900C
`define EDS_OFF_RX_MAX 16'h9010
`define EDS_OFF_STATUS 16'h9014
`define EDS_OFF_TEST 16'h9018
`define EDS_CAM_BASE 16'h9100
`define EDS_CAM_TOP 16'h917C
`define EDS_TXBUF_BASE 16'h9200
`define EDS_TXBUF_TOP 16'h92FC
`define EDS_RXEOF_BASE 16'h9800
`define EDS_RXEOF_TOP 16'h98FC
`define EDS_RXDAT_BASE 16'h9900
`define EDS_RXDAT_TOP 16'h99FC
`define EDS_RST_ZERO 32'h00000000
`define EDS_RST_PTR 32'hFFFFFFFF
`define EDS_TXCTL_EN 14
`define EDS_RX_OVERFLOW 26
`define EDS_RX_LONG 27
`define EDS_RX_PARITY 29
`define EDS_RX_GOOD 30
`define EDS_RX_HALTED 31
`define EDS_TX_CNT_LO 16
`define EDS_TX_TOO_MANY_COLLISIONS 20
`define EDS_TX_IRQ 23
`define EDS_TX_UNDER 24
`define EDS_TX_DEFER 25
`define EDS_TX_NOCARR 26
`define EDS_TX_SQE 27
`define EDS_TX_LATE 28
`define EDS_TX_PARITY 29
`define EDS_TX_COMP 30
`define EDS_TX_HALTED 31
`define EDS_MAX_FRAME 1518
`define EDS_LATE_BYTES 64
`define EDS_CLK_NS 100
`define EDS_DEFER100_NS 327680
`define EDS_DEFER10_NS 3276800
`define EDS_SQE_NS 1600
`define EDS_DEFER100_CYC (`EDS_DEFER100_NS / `EDS_CLK_NS)
`define EDS_DEFER10_CYC (`EDS_DEFER10_NS / `EDS_CLK_NS)
`define EDS_SQE_CYC (`EDS_SQE_NS / `EDS_CLK_NS)
`endif

// *** rtl/eds_core.sv ***
// Descriptor status builder, buffered DMA registers and buffer test windows
//
// The plain strobed port was chosen for this implementation.
`include "eds_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module eds_core #(
    parameter int DEFER10_CYCLES = `EDS_DEFER10_CYC,
    parameter int BUF_DEPTH = 64
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic phy_col,
    input wire logic phy_crs,
    input wire logic speed_10,
    input wire logic immediate_halt,
    input wire logic rx_run_enable,
    input wire logic rx_long_enable,
    input wire logic rx_good_irq_enable,
    input wire logic tx_done_irq_enable,
    input wire logic tx_start,
    input wire logic tx_byte,
    input wire logic tx_end,
    input wire logic tx_fifo_empty,
    input wire logic tx_fifo_parity_fault,
    input wire logic tx_defer_active,
    input wire logic rx_start,
    input wire logic rx_byte,
    input wire logic rx_fifo_full,
    input wire logic rx_fifo_parity_fault,
    input wire logic rx_end,
    input wire eds_pkg::eds_rx_entry_s rx_entry,
    input wire logic rx_entry_valid,
    output logic rx_good_irq,
    output logic tx_busy,
    output logic wb_valid,
    output eds_pkg::eds_wb_s wb_data,
    input wire logic wb_ready
);
    // Register file
    logic [31:0] dma_tx_control;
    logic [31:0] dma_rx_control;
    logic [31:0] tx_descriptor_start_pointer;
    logic [31:0] rx_descriptor_start_pointer;
    logic [31:0] rx_frame_max_size;
    logic [31:0] dma_status;
    logic test_mode;
    logic [31:0] address_match_table [32];
    logic [31:0] tx_buf [BUF_DEPTH];
    eds_pkg::eds_rx_entry_s rx_buf [BUF_DEPTH];
    logic [5:0] rx_wr_idx;
    // Pin synchronisers and edge detect
    logic col_meta, col_sync, col_last, crs_meta, crs_sync;
    logic col_rise;
    // Transmit status state
    eds_pkg::eds_tx_state_e tx_state;
    logic [3:0] tx_coll_cnt;
    logic tx_too_many_collisions, tx_under, tx_defer, tx_carrier_seen, tx_sqe, tx_late, tx_par, tx_halt;
    logic [10:0] tx_bytes;
    logic [15:0] defer_cnt;
    logic [4:0] sqe_cnt;
    logic tx_err, tx_irq;
    logic [31:0] tx_word;
    // Receive status state
    logic rx_active, rx_pending;
    logic rx_ovf, rx_par, rx_halt;
    logic [11:0] rx_bytes;
    logic [31:0] rx_word;
    logic tx_halt_req, wb_take;
    logic [15:0] defer_limit;

    // Decide whether an address falls in a window
    function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction

    // Word index inside a window
    function automatic logic [5:0] win_idx(input logic [15:0] a, input logic [15:0] lo);
        logic [15:0] d;
        d = a - lo;
        win_idx = d[7:2];
    endfunction

    // Two-flop synchronisers for the PHY pins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            col_meta <= 1'b0;
            col_sync <= 1'b0;
            col_last <= 1'b0;
            crs_meta <= 1'b0;
            crs_sync <= 1'b0;
        end else begin
            col_meta <= phy_col;
            col_sync <= col_meta;
            col_last <= col_sync;
            crs_meta <= phy_crs;
            crs_sync <= crs_meta;
        end
    end
    assign col_rise = col_sync & ~col_last;

    // Halt request: enable cleared or immediate halt
    assign tx_halt_req = immediate_halt | ~dma_tx_control[`EDS_TXCTL_EN];
    assign defer_limit = speed_10 ? 16'(DEFER10_CYCLES) : 16'(`EDS_DEFER100_CYC);

    // Control registers; pointers keep the low bits software gives
    // aligned pointers assumed
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dma_tx_control <= `EDS_RST_ZERO;
            dma_rx_control <= `EDS_RST_ZERO;
            tx_descriptor_start_pointer <= `EDS_RST_PTR;
            rx_descriptor_start_pointer <= `EDS_RST_PTR;
            rx_frame_max_size <= `EDS_RST_ZERO;
            test_mode <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                `EDS_OFF_TX_CTRL: dma_tx_control <= reg_wdata;
                `EDS_OFF_RX_CTRL: dma_rx_control <= reg_wdata;
                `EDS_OFF_TX_PTR: tx_descriptor_start_pointer <= reg_wdata;
                `EDS_OFF_RX_PTR: rx_descriptor_start_pointer <= reg_wdata;
                `EDS_OFF_RX_MAX: rx_frame_max_size <= reg_wdata;
                `EDS_OFF_TEST: test_mode <= reg_wdata[0];
                default: ;
            endcase
        end
    end

    // DMA status: bit0 tx status written back, bit1 rx; write one clears, set wins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dma_status <= `EDS_RST_ZERO;
        end else begin
            dma_status[0] <= (wb_take & wb_data.is_tx) |
                (dma_status[0] & ~(reg_wr && reg_addr == `EDS_OFF_STATUS && reg_wdata[0]));
            dma_status[1] <= (wb_take & ~wb_data.is_tx) |
                (dma_status[1] & ~(reg_wr && reg_addr == `EDS_OFF_STATUS && reg_wdata[1]));
        end
    end

    // Address match table and transmit buffer storage
    // test-mode buffer writes
    always_ff @(posedge ref_clk) begin
        if (reg_wr && in_win(reg_addr, `EDS_CAM_BASE, `EDS_CAM_TOP)) begin
            address_match_table[5'(win_idx(reg_addr, `EDS_CAM_BASE))] <= reg_wdata;
        end
        if (reg_wr && test_mode && in_win(reg_addr, `EDS_TXBUF_BASE, `EDS_TXBUF_TOP)) begin
            tx_buf[win_idx(reg_addr, `EDS_TXBUF_BASE)] <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rx_entry_valid) begin
            rx_buf[rx_wr_idx] <= rx_entry;
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_wr_idx <= 6'h00;
        end else if (rx_entry_valid) begin
            rx_wr_idx <= rx_wr_idx + 6'h01;
        end
    end

    // Register read mux, data one cycle after the strobe
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= 32'h00000000;
            case (reg_addr)
                `EDS_OFF_TX_CTRL: reg_rdata <= dma_tx_control;
                `EDS_OFF_RX_CTRL: reg_rdata <= dma_rx_control;
                `EDS_OFF_TX_PTR: reg_rdata <= tx_descriptor_start_pointer;
                `EDS_OFF_RX_PTR: reg_rdata <= rx_descriptor_start_pointer;
                `EDS_OFF_RX_MAX: reg_rdata <= rx_frame_max_size;
                `EDS_OFF_STATUS: reg_rdata <= dma_status;
                `EDS_OFF_TEST: reg_rdata <= {31'h00000000, test_mode};
                default: begin
                    if (test_mode && in_win(reg_addr, `EDS_TXBUF_BASE, `EDS_TXBUF_TOP)) begin
                        reg_rdata <= tx_buf[win_idx(reg_addr, `EDS_TXBUF_BASE)];
                    end
                    if (in_win(reg_addr, `EDS_RXEOF_BASE, `EDS_RXEOF_TOP)) begin
                        reg_rdata <= {31'h00000000, rx_buf[win_idx(reg_addr, `EDS_RXEOF_BASE)].eof};
                    end
                    if (in_win(reg_addr, `EDS_RXDAT_BASE, `EDS_RXDAT_TOP)) begin
                        reg_rdata <= rx_buf[win_idx(reg_addr, `EDS_RXDAT_BASE)].data;
                    end
                end
            endcase
        end
    end

    // Transmit sequencer
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_state <= eds_pkg::EDS_TX_IDLE;
            sqe_cnt <= 5'h00;
        end else begin
            case (tx_state)
                eds_pkg::EDS_TX_IDLE: begin
                    if (tx_start) begin
                        tx_state <= eds_pkg::EDS_TX_SEND;
                    end
                end
                eds_pkg::EDS_TX_SEND: begin
                    sqe_cnt <= 5'h00;
                    if (tx_halt_req || (col_rise && tx_coll_cnt == 4'hF)) begin
                        tx_state <= eds_pkg::EDS_TX_WB;
                    end else if (tx_end) begin
                        tx_state <= eds_pkg::EDS_TX_SQE_WAIT;
                    end
                end
                eds_pkg::EDS_TX_SQE_WAIT: begin
                    sqe_cnt <= sqe_cnt + 5'h01;
                    if (col_sync || sqe_cnt == 5'(`EDS_SQE_CYC - 1)) begin
                        tx_state <= eds_pkg::EDS_TX_WB;
                    end
                end
                eds_pkg::EDS_TX_WB: begin
                    if (wb_ready) begin
                        tx_state <= eds_pkg::EDS_TX_IDLE;
                    end
                end
                default: tx_state <= eds_pkg::EDS_TX_IDLE;
            endcase
        end
    end
    assign tx_busy = (tx_state != eds_pkg::EDS_TX_IDLE);

    // Transmit event capture per packet
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_coll_cnt <= 4'h0;
            tx_too_many_collisions <= 1'b0;
            tx_under <= 1'b0;
            tx_defer <= 1'b0;
            tx_carrier_seen <= 1'b0;
            tx_sqe <= 1'b0;
            tx_late <= 1'b0;
            tx_par <= 1'b0;
            tx_halt <= 1'b0;
            tx_bytes <= 11'h000;
            defer_cnt <= 16'h0000;
        end else if (tx_state == eds_pkg::EDS_TX_IDLE && tx_start) begin
            tx_coll_cnt <= 4'h0;
            tx_too_many_collisions <= 1'b0;
            tx_under <= 1'b0;
            tx_defer <= 1'b0;
            tx_carrier_seen <= 1'b0;
            tx_sqe <= 1'b0;
            tx_late <= 1'b0;
            tx_par <= 1'b0;
            tx_halt <= 1'b0;
            tx_bytes <= 11'h000;
            defer_cnt <= 16'h0000;
        end else if (tx_state == eds_pkg::EDS_TX_SEND) begin
            if (tx_byte && tx_bytes != 11'h7FF) begin
                tx_bytes <= tx_bytes + 11'h001;
            end
            if (col_rise) begin
                tx_coll_cnt <= tx_coll_cnt + 4'h1;
                if (tx_coll_cnt == 4'hF) begin
                    tx_too_many_collisions <= 1'b1;
                end
                if (tx_bytes >= 11'(`EDS_LATE_BYTES)) begin
                    tx_late <= 1'b1;
                end
            end
            if (tx_fifo_empty) begin
                tx_under <= 1'b1;
            end
            if (crs_sync) begin
                tx_carrier_seen <= 1'b1;
            end
            if (tx_fifo_parity_fault) begin
                tx_par <= 1'b1;
            end
            if (tx_halt_req) begin
                tx_halt <= 1'b1;
            end
            if (!tx_defer_active) begin
                defer_cnt <= 16'h0000;
            end else if (defer_cnt + 16'h0001 >= defer_limit) begin
                tx_defer <= 1'b1;
            end else begin
                defer_cnt <= defer_cnt + 16'h0001;
            end
        end else if (tx_state == eds_pkg::EDS_TX_SQE_WAIT) begin
            if (!col_sync && sqe_cnt == 5'(`EDS_SQE_CYC - 1)) begin
                tx_sqe <= 1'b1;
            end
        end
    end

    // Transmit status word
    always_comb begin
        tx_err = tx_too_many_collisions | tx_under | tx_defer | ~tx_carrier_seen | tx_sqe | tx_late | tx_par;
        tx_irq = tx_err | tx_done_irq_enable;
        tx_word = 32'h00000000;
        tx_word[`EDS_TX_CNT_LO +: 4] = tx_coll_cnt;
        tx_word[`EDS_TX_TOO_MANY_COLLISIONS] = tx_too_many_collisions;
        tx_word[`EDS_TX_IRQ] = tx_irq;
        tx_word[`EDS_TX_UNDER] = tx_under;
        tx_word[`EDS_TX_DEFER] = tx_defer;
        tx_word[`EDS_TX_NOCARR] = ~tx_carrier_seen;
        tx_word[`EDS_TX_SQE] = tx_sqe;
        tx_word[`EDS_TX_LATE] = tx_late;
        tx_word[`EDS_TX_PARITY] = tx_par;
        tx_word[`EDS_TX_COMP] = 1'b1;
        tx_word[`EDS_TX_HALTED] = tx_halt | tx_err;
    end

    // Receive event capture per frame
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_active <= 1'b0;
            rx_pending <= 1'b0;
            rx_ovf <= 1'b0;
            rx_par <= 1'b0;
            rx_halt <= 1'b0;
            rx_bytes <= 12'h000;
        end else if (rx_pending) begin
            if (wb_take && !wb_data.is_tx) begin
                rx_pending <= 1'b0;
            end
        end else if (rx_start && !rx_active) begin
            rx_active <= 1'b1;
            rx_ovf <= 1'b0;
            rx_par <= 1'b0;
            rx_halt <= 1'b0;
            rx_bytes <= 12'h000;
        end else if (rx_active) begin
            if (rx_byte && rx_bytes != 12'hFFF) begin
                rx_bytes <= rx_bytes + 12'h001;
            end
            if (rx_byte && rx_fifo_full) begin
                rx_ovf <= 1'b1;
            end
            if (rx_fifo_parity_fault) begin
                rx_par <= 1'b1;
            end
            if (!rx_run_enable || immediate_halt) begin
                rx_halt <= 1'b1;
                rx_active <= 1'b0;
                rx_pending <= 1'b1;
            end else if (rx_end) begin
                rx_active <= 1'b0;
                rx_pending <= 1'b1;
            end
        end
    end

    // Receive status word
    always_comb begin
        rx_word = 32'h00000000;
        rx_word[`EDS_RX_OVERFLOW] = rx_ovf;
        rx_word[`EDS_RX_LONG] = (rx_bytes > 12'(`EDS_MAX_FRAME)) & ~rx_long_enable;
        rx_word[`EDS_RX_PARITY] = rx_par;
        rx_word[`EDS_RX_GOOD] = ~(rx_ovf | rx_par | rx_halt | rx_word[`EDS_RX_LONG]);
        rx_word[`EDS_RX_HALTED] = rx_halt;
    end

    // Write-back port; transmit goes first when both wait
    // status write-back
    always_comb begin
        wb_valid = (tx_state == eds_pkg::EDS_TX_WB) | rx_pending;
        wb_data.is_tx = (tx_state == eds_pkg::EDS_TX_WB);
        wb_data.word = wb_data.is_tx ? tx_word : rx_word;
    end
    assign wb_take = wb_valid & wb_ready;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_good_irq <= 1'b0;
        end else begin
            rx_good_irq <= wb_take & ~wb_data.is_tx & rx_word[`EDS_RX_GOOD] & rx_good_irq_enable;
        end
    end

    // Checks
    AST_RX_OVF: assert property (@(posedge ref_clk) disable iff (!resetn)
        rx_active && !rx_pending && rx_byte && rx_fifo_full |=> rx_ovf)
        else $error("overflow not flagged");
    AST_RX_LONG: assert property (@(posedge ref_clk) disable iff (!resetn)
        rx_long_enable |-> !rx_word[`EDS_RX_LONG])
        else $error("long flag with long enable");
    AST_RX_PAR: assert property (@(posedge ref_clk) disable iff (!resetn)
        rx_active && !rx_pending && rx_fifo_parity_fault |=> rx_par)
        else $error("rx parity lost");
    AST_RX_IRQ: assert property (@(posedge ref_clk) disable iff (!resetn)
        rx_good_irq |-> $past(rx_good_irq_enable) && $past(wb_take))
        else $error("stray good interrupt");
    AST_RX_HALT: assert property (@(posedge ref_clk) disable iff (!resetn)
        rx_active && !rx_pending && !rx_run_enable |=> rx_pending && rx_word[`EDS_RX_HALTED])
        else $error("rx halt missed");
    AST_TX_EXC: assert property (@(posedge ref_clk) disable iff (!resetn)
        tx_state == eds_pkg::EDS_TX_SEND && col_rise && tx_coll_cnt == 4'hF |=>
        tx_too_many_collisions && tx_coll_cnt == 4'h0 && tx_state == eds_pkg::EDS_TX_WB)
        else $error("sixteenth collision wrong");
    AST_TX_SQE: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(tx_state == eds_pkg::EDS_TX_SQE_WAIT) |-> ##[1:16] tx_state != eds_pkg::EDS_TX_SQE_WAIT)
        else $error("collision test wait too long");
    AST_TX_UND: assert property (@(posedge ref_clk) disable iff (!resetn)
        tx_state == eds_pkg::EDS_TX_SEND && tx_fifo_empty |=> tx_word[`EDS_TX_UNDER])
        else $error("underrun missed");
    AST_TX_WB: assert property (@(posedge ref_clk) disable iff (!resetn)
        tx_state == eds_pkg::EDS_TX_WB && !wb_ready |=> tx_state == eds_pkg::EDS_TX_WB && wb_valid)
        else $error("descriptor left before write-back");
endmodule
`default_nettype wire

// *** rtl/eds_pkg.sv ***
// Types shared by the descriptor status block
package eds_pkg;
    typedef enum logic [3:0] {
        EDS_TX_IDLE = 4'h1,
        EDS_TX_SEND = 4'h2,
        EDS_TX_SQE_WAIT = 4'h4,
        EDS_TX_WB = 4'h8
    } eds_tx_state_e;
    typedef struct packed {
        logic is_tx;
        logic [31:0] word;
    } eds_wb_s;
    // Frame-end flag sits in the top bit, above the data word
    typedef struct packed {
        logic eof;
        logic [31:0] data;
    } eds_rx_entry_s;
endpackage
